// file: design/lcsc_buf2.sv
`timescale 1ns/1ps
module lcsc_buf2
  import lcsc_pkg::*;
#(
  parameter int WIDTH = ENTRY_W,
  parameter int DEPTH = 2
)
(
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ff;
  logic [PW-1:0]    nxt_wr;
  logic [PW-1:0]    rd_ff;
  logic [PW-1:0]    nxt_rd;
  logic [PW:0]      cnt_ff;
  logic [PW:0]      nxt_cnt;
  logic             push;
  logic             pop;

  // Honest flags straight from the fill count
  assign in_ready_o  = (cnt_ff != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem_ff[rd_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer and count update
  always_comb
  begin
    nxt_wr  = wr_ff;
    nxt_rd  = rd_ff;
    nxt_cnt = cnt_ff;
    if (push)
      nxt_wr = (wr_ff == PW'(DEPTH-1)) ? '0 : wr_ff + PW'(1);
    if (pop)
      nxt_rd = (rd_ff == PW'(DEPTH-1)) ? '0 : rd_ff + PW'(1);
    if (push && !pop)
      nxt_cnt = cnt_ff + (PW+1)'(1);
    else if (pop && !push)
      nxt_cnt = cnt_ff - (PW+1)'(1);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage needs no reset; valid is guarded by the count
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
      mem_ff[wr_ff] <= in_data_i;
  end

endmodule

// file: design/lcsc_loader.sv
`timescale 1ns/1ps
// What this block does
// RL1 - The enable shift register runs in either direction, picked by the direction select level.
// RL2 - The enable position decides which data register columns take the incoming nibble.
// RL3 - While not enabled, the internal shift clock and data bus are held low to save power.
// RL4 - In a cascade the enables are chained and the first driver's enable input is tied high.
// RL5 - After 80 bits the block hands the enable on by itself, with no controller signal.
// RL6 - Serial data maps to columns in a fixed way, whatever the number of shift clock edges.
// RL7 - On each falling edge of the latch pulse the whole data register is copied to the latch.
// RL8 - With blank inactive, a set bit gives top or bottom level and a clear bit upper or lower mid.
// RL9 - The controller stretches the shift clock period where it inserts the latch pulse.
// RL10 - While forced blank is low every column is driven to the top level.
// RL11 - The nibble is taken on the falling edge of the shift clock.
// RL12 - The enable output is reset by the latch pulse and rises by itself after 80 bits.
// RL13 - One chain enable pin is the input and the other the output, by direction select.
// RL14 - After each latch pulse the enable position restarts at the first group for the direction.
module lcsc_loader
  import lcsc_pkg::*;
#(
  parameter int COLS   = COL_COUNT,
  parameter int GROUPS = GROUP_COUNT
)
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              pixel_shift_clock_i,
  input  wire logic              line_latch_pulse_i,
  input  wire logic              frame_alternation_i,
  input  wire logic              forced_blank_n_i,
  input  wire logic [3:0]        pixel_nibble_in_i,
  input  wire logic              shift_direction_select_i,
  input  wire logic              chain_enable_a_i,
  output logic                   chain_enable_a_o,
  output logic                   chain_enable_a_oe_n_o,
  input  wire logic              chain_enable_b_i,
  output logic                   chain_enable_b_o,
  output logic                   chain_enable_b_oe_n_o,
  output logic [2*COLS-1:0]      column_outputs_o,
  output logic                   sample_ready_o,
  output logic                   sample_overrun_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int SYNC_W = 7 + NIB_WIDTH;

  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] s1_ff;
  logic [SYNC_W-1:0] s2_ff;
  logic [SYNC_W-1:0] nxt_s1;
  logic [SYNC_W-1:0] nxt_s2;

  assign pins = {pixel_shift_clock_i, line_latch_pulse_i, frame_alternation_i,
                 forced_blank_n_i, shift_direction_select_i, chain_enable_a_i,
                 chain_enable_b_i, pixel_nibble_in_i};

  // Two stages; only s2 is read by logic
  always_comb
  begin
    nxt_s1 = pins;
    nxt_s2 = s1_ff;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
    end
    else
    begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end

  logic                 shclk_s;
  logic                 latch_s;
  logic                 alt_s;
  logic                 blank_n_s;
  logic                 dir_s;
  logic                 en_a_s;
  logic                 en_b_s;
  logic [NIB_WIDTH-1:0] nib_s;

  assign shclk_s   = s2_ff[SYNC_W-1];
  assign latch_s   = s2_ff[SYNC_W-2];
  assign alt_s     = s2_ff[SYNC_W-3];
  assign blank_n_s = s2_ff[SYNC_W-4];
  assign dir_s     = s2_ff[SYNC_W-5];
  assign en_a_s    = s2_ff[SYNC_W-6];
  assign en_b_s    = s2_ff[SYNC_W-7];
  assign nib_s     = s2_ff[NIB_WIDTH-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Chain enable and edge detection

  logic                 done_ff;
  logic                 nxt_done;
  logic                 chain_in;
  logic                 active;
  logic                 gclk;
  logic                 gclk_d_ff;
  logic                 latch_d_ff;
  logic                 latch_pend_ff;
  logic                 nxt_latch_pend;
  logic                 overrun_ff;
  logic                 nxt_overrun;
  logic [NIB_WIDTH-1:0] gdata;
  logic                 shift_fall;
  logic                 latch_fall;

  // Direction low: pin a listens, pin b drives; high: the reverse
  assign chain_in = dir_s ? en_b_s : en_a_s; // RL13
  assign active   = chain_in && !done_ff;

  // Gated clock and bus stay low while not enabled
  assign gclk  = shclk_s && active; // RL3
  assign gdata = active ? nib_s : '0; // RL3

  assign shift_fall = gclk_d_ff && !gclk; // RL11
  assign latch_fall = latch_d_ff && !latch_s; // RL7

  assign chain_enable_a_o      = dir_s ? done_ff : 1'b0;
  assign chain_enable_a_oe_n_o = !dir_s; // RL13
  assign chain_enable_b_o      = dir_s ? 1'b0 : done_ff;
  assign chain_enable_b_oe_n_o = dir_s; // RL13

  ////////////////////////////////////////////////////////////////////////////
  // Entry buffer between capture and data register

  logic               buf_in_valid;
  logic               buf_in_ready;
  logic [ENTRY_W-1:0] buf_in_data;
  logic               buf_out_valid;
  logic               buf_out_ready;
  logic [ENTRY_W-1:0] buf_out_data;

  // Nibble goes first; a latch edge waits so it never overtakes data
  always_comb
  begin
    buf_in_valid   = shift_fall || latch_pend_ff || latch_fall;
    buf_in_data    = shift_fall ? {1'b0, gdata} : {1'b1, {NIB_WIDTH{1'b0}}};
    nxt_latch_pend = latch_pend_ff;
    if (!shift_fall && buf_in_ready)
      nxt_latch_pend = 1'b0;
    // Park the latch edge only when it could not enter now, else it copies twice
    if (latch_fall && (shift_fall || !buf_in_ready))
      nxt_latch_pend = 1'b1;
    nxt_overrun = overrun_ff || (shift_fall && !buf_in_ready);
  end

  assign sample_ready_o   = buf_in_ready;
  assign sample_overrun_o = overrun_ff;

  lcsc_buf2 #(
    .WIDTH (ENTRY_W),
    .DEPTH (2)
  ) u_buf (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_valid_i  (buf_in_valid),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (buf_in_data),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_out_ready),
    .out_data_o  (buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Drain: write nibbles, copy on latch entries

  lcsc_drain_t          st_ff;
  lcsc_drain_t          nxt_st;
  logic [GROUP_W-1:0]   group_ff;
  logic [GROUP_W-1:0]   nxt_group;
  logic                 wr_nib;
  logic                 do_copy;
  logic [COLS-1:0]      data_ff;
  logic [COLS-1:0]      nxt_data;
  logic [COLS-1:0]      latch_ff;
  logic [COLS-1:0]      nxt_latch;

  // Settle cycle after a copy stalls the buffer for one clock
  assign buf_out_ready = (st_ff == LCSC_RUN);
  assign wr_nib        = buf_out_valid && buf_out_ready && !buf_out_data[ENTRY_MARK];
  assign do_copy       = buf_out_valid && buf_out_ready && buf_out_data[ENTRY_MARK];

  always_comb
  begin
    nxt_st    = st_ff;
    nxt_group = group_ff;
    nxt_done  = done_ff;
    unique case (st_ff)
      LCSC_RUN:
      begin
        if (do_copy)
        begin
          nxt_st    = LCSC_SETTLE;
          nxt_group = GROUP_RST; // RL14
          nxt_done  = 1'b0; // RL12
        end
        else if (wr_nib)
        begin
          nxt_group = group_ff + GROUP_W'(1); // RL1
          if (group_ff == GROUP_W'(GROUPS-1))
            nxt_done = 1'b1; // RL5 RL12
        end
      end
      LCSC_SETTLE:
        nxt_st = LCSC_RUN;
    endcase
  end

  // Fixed column for each group, mirrored by direction
  genvar c;
  generate
    for (c = 0; c < COLS; c++)
    begin : g_col
      localparam int FWD_G = c / NIB_WIDTH;
      localparam int FWD_B = NIB_WIDTH - 1 - (c % NIB_WIDTH);
      localparam int REV_G = (COLS - 1 - c) / NIB_WIDTH;
      localparam int REV_B = NIB_WIDTH - 1 - ((COLS - 1 - c) % NIB_WIDTH);
      logic hit;

      always_comb
      begin
        hit = dir_s ? (group_ff == GROUP_W'(REV_G)) : (group_ff == GROUP_W'(FWD_G)); // RL2
        nxt_data[c] = data_ff[c];
        if (wr_nib && hit)
          nxt_data[c] = buf_out_data[dir_s ? REV_B : FWD_B]; // RL6
        nxt_latch[c] = do_copy ? data_ff[c] : latch_ff[c]; // RL7
      end

      // Level select per column
      logic [1:0] lvl;
      always_comb
      begin
        if (!blank_n_s)
          lvl = LVL_TOP; // RL10
        else if (latch_ff[c])
          lvl = alt_s ? LVL_TOP : LVL_BOTTOM; // RL8
        else
          lvl = alt_s ? LVL_UPPER_MID : LVL_LOWER_MID; // RL8
      end

      always_ff @(posedge clk_sys_i)
      begin
        if (rst_i)
          column_outputs_o[2*c +: 2] <= LVL_RST;
        else
          column_outputs_o[2*c +: 2] <= lvl;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      st_ff         <= LCSC_RUN;
      group_ff      <= GROUP_RST;
      done_ff       <= 1'b0;
      data_ff       <= '0;
      latch_ff      <= '0;
      gclk_d_ff     <= 1'b0;
      latch_d_ff    <= 1'b0;
      latch_pend_ff <= 1'b0;
      overrun_ff    <= 1'b0;
    end
    else
    begin
      st_ff         <= nxt_st;
      group_ff      <= nxt_group;
      done_ff       <= nxt_done;
      data_ff       <= nxt_data;
      latch_ff      <= nxt_latch;
      gclk_d_ff     <= gclk;
      latch_d_ff    <= latch_s;
      latch_pend_ff <= nxt_latch_pend;
      overrun_ff    <= nxt_overrun;
    end
  end

endmodule

// file: inc/lcsc_pkg.sv
package lcsc_pkg;

  // Line geometry
  localparam int COL_COUNT   = 80;
  localparam int NIB_WIDTH   = 4;
  localparam int GROUP_COUNT = COL_COUNT / NIB_WIDTH;
  localparam int GROUP_W     = 5;

  // Buffer entry layout: marker bit above the nibble
  localparam int ENTRY_W     = NIB_WIDTH + 1;
  localparam int ENTRY_MARK  = NIB_WIDTH;

  // Column drive level codes, two bits per column
  localparam logic [1:0] LVL_TOP       = 2'h0;
  localparam logic [1:0] LVL_UPPER_MID = 2'h1;
  localparam logic [1:0] LVL_LOWER_MID = 2'h2;
  localparam logic [1:0] LVL_BOTTOM    = 2'h3;

  // Reset values
  localparam logic [GROUP_W-1:0] GROUP_RST = 5'h00;
  localparam logic [1:0]         LVL_RST   = LVL_TOP;

  // Drain side of the loader
  typedef enum logic [1:0]
  {
    LCSC_RUN    = 2'h1,
    LCSC_SETTLE = 2'h2
  } lcsc_drain_t;

endpackage

// file: tb/lcsc_ctrl_model.sv
`timescale 1ns/1ps
module lcsc_ctrl_model
(
  input  wire logic       clk_sys_i,
  output logic            pixel_shift_clock_o,
  output logic            line_latch_pulse_o,
  output logic [3:0]      pixel_nibble_o
);
  // Idle bus: clock and latch low, data parked
  initial
  begin
    pixel_shift_clock_o = 1'b0;
    line_latch_pulse_o  = 1'b0;
    pixel_nibble_o      = 4'h0;
  end
  // One nibble, four system cycles per clock phase
  task automatic shift(input logic [3:0] nib);
    @(negedge clk_sys_i);
    pixel_nibble_o      = nib;
    pixel_shift_clock_o = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    pixel_shift_clock_o = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    pixel_nibble_o = ~nib; // Hold over, so stale data cannot pass for valid
  endtask
  // Latch pulse, then a stretched gap before any further shift
  task automatic latch();
    @(negedge clk_sys_i);
    line_latch_pulse_o = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    line_latch_pulse_o = 1'b0;
    repeat (8) @(negedge clk_sys_i);
  endtask
endmodule

// file: tb/lcsc_loader_props.sv
`timescale 1ns/1ps
module lcsc_loader_props
  import lcsc_pkg::*;
#(
  parameter int COLS = COL_COUNT
)
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              line_latch_pulse_i,
  input  wire logic              frame_alternation_i,
  input  wire logic              forced_blank_n_i,
  input  wire logic              shift_direction_select_i,
  input  wire logic              chain_enable_a_o,
  input  wire logic              chain_enable_a_oe_n_o,
  input  wire logic              chain_enable_b_o,
  input  wire logic              chain_enable_b_oe_n_o,
  input  wire logic [2*COLS-1:0] column_outputs_o,
  input  wire logic              sample_overrun_o
);
  logic [COLS-1:0] lvl_hi;
  // Upper code bit of each column marks the alternation half
  always_comb
  begin
    for (int c = 0; c < COLS; c++)
      lvl_hi[c] = column_outputs_o[2*c+1];
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Pin levels held long enough to pass the sync flops
  sequence blank_held;  !forced_blank_n_i[*6]; endsequence
  sequence alt_hi_held; (forced_blank_n_i && frame_alternation_i)[*6]; endsequence
  sequence alt_lo_held; (forced_blank_n_i && !frame_alternation_i)[*6]; endsequence
  blank_top_a: assert property (blank_held |-> column_outputs_o == '0)
    else $error("columns not at top level while blanked");
  alt_high_a: assert property (alt_hi_held |-> lvl_hi == '0)
    else $error("column level wrong for alternation high");
  alt_low_a: assert property (alt_lo_held |-> lvl_hi == '1)
    else $error("column level wrong for alternation low");
  dir_low_a: assert property (!shift_direction_select_i[*4]
    |-> chain_enable_a_oe_n_o && !chain_enable_b_oe_n_o)
    else $error("enable pin roles wrong for direction low");
  dir_high_a: assert property (shift_direction_select_i[*4]
    |-> !chain_enable_a_oe_n_o && chain_enable_b_oe_n_o)
    else $error("enable pin roles wrong for direction high");
  input_pin_low_a: assert property (!(chain_enable_a_oe_n_o && chain_enable_a_o)
    && !(chain_enable_b_oe_n_o && chain_enable_b_o))
    else $error("enable output high on the input pin");
  latch_clear_a: assert property ($fell(line_latch_pulse_i)
    |-> ##[1:8] !(chain_enable_a_o || chain_enable_b_o))
    else $error("enable output not reset by latch pulse");
  no_overrun_a: assert property (!sample_overrun_o)
    else $error("nibble lost at a legal shift rate");
endmodule

// file: tb/lcsc_loader_tb.sv
`timescale 1ns/1ps
module lcsc_loader_tb
  import lcsc_pkg::*;
;
  logic                     clk_sys_i, rst_i, frame_alternation_i, forced_blank_n_i;
  logic                     shift_direction_select_i, en_in;
  logic                     pixel_shift_clock_i, line_latch_pulse_i;
  logic [3:0]               pixel_nibble_in_i;
  logic                     chain_enable_a_i, chain_enable_a_o, chain_enable_a_oe_n_o;
  logic                     chain_enable_b_i, chain_enable_b_o, chain_enable_b_oe_n_o;
  logic [2*COL_COUNT-1:0]   column_outputs_o;
  logic                     sample_ready_o, sample_overrun_o;
  int                       failures, checks_done, cycles;
  // Input pin sees the upstream enable, held high as first in chain except in t_off, which drives it low
  assign chain_enable_a_i = chain_enable_a_oe_n_o ? en_in : chain_enable_a_o;
  assign chain_enable_b_i = chain_enable_b_oe_n_o ? en_in : chain_enable_b_o;
  lcsc_loader i_lcsc_loader (.clk_sys_i, .rst_i, .pixel_shift_clock_i, .line_latch_pulse_i,
    .frame_alternation_i, .forced_blank_n_i, .pixel_nibble_in_i, .shift_direction_select_i,
    .chain_enable_a_i, .chain_enable_a_o, .chain_enable_a_oe_n_o, .chain_enable_b_i,
    .chain_enable_b_o, .chain_enable_b_oe_n_o, .column_outputs_o, .sample_ready_o,
    .sample_overrun_o);
  lcsc_ctrl_model i_lcsc_ctrl_model (.clk_sys_i, .pixel_shift_clock_o(pixel_shift_clock_i),
    .line_latch_pulse_o(line_latch_pulse_i), .pixel_nibble_o(pixel_nibble_in_i));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // Column codes from one bit per column and the alternation level
  function automatic logic [2*COL_COUNT-1:0] exp_cols(input logic [79:0] d, input logic alt);
    for (int c = 0; c < COL_COUNT; c++)
      exp_cols[2*c+:2] = d[c] ? (alt ? LVL_TOP : LVL_BOTTOM)
                              : (alt ? LVL_UPPER_MID : LVL_LOWER_MID);
  endfunction
  // Nibbles lo..hi-1; those past the line carry filler
  task automatic send(input logic dir, input logic [79:0] d, input int lo, input int hi);
    logic [3:0] nb;
    for (int k = lo; k < hi; k++)
    begin
      nb = k[3:0];
      if (k < 20)
        for (int j = 0; j < 4; j++)
          nb[3-j] = dir ? d[79-4*k-j] : d[4*k+j];
      i_lcsc_ctrl_model.shift(nb);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Full line with enable hand-over, overlong line, latch and both alternation halves
  task automatic t_line(input logic dir, input logic [79:0] d);
    shift_direction_select_i = dir;
    wt(4);
    send(dir, d, 0, 19);
    wt(8);
    check(dir ? chain_enable_a_o : chain_enable_b_o, 1'b0);
    send(dir, d, 19, 22);
    wt(8);
    check(dir ? chain_enable_a_o : chain_enable_b_o, 1'b1);
    i_lcsc_ctrl_model.latch();
    check(chain_enable_a_o | chain_enable_b_o, 1'b0);
    frame_alternation_i = 1'b1;
    wt(8);
    check(column_outputs_o, exp_cols(d, 1'b1));
    frame_alternation_i = 1'b0;
    wt(8);
    check(column_outputs_o, exp_cols(d, 1'b0));
  endtask
  // Line sent while not enabled must leave the data register alone
  task automatic t_off(input logic [79:0] d);
    shift_direction_select_i = 1'b0;
    en_in = 1'b0;
    wt(4);
    send(1'b0, ~d, 0, 20);
    wt(8);
    check(chain_enable_b_o, 1'b0);
    i_lcsc_ctrl_model.latch();
    check(column_outputs_o, exp_cols(d, 1'b0));
    en_in = 1'b1;
  endtask
  // Forced blank overrides data, then releases back to it
  task automatic t_blank(input logic [79:0] d);
    forced_blank_n_i = 1'b0;
    wt(8);
    check(column_outputs_o, '0);
    forced_blank_n_i = 1'b1;
    wt(8);
    check(column_outputs_o, exp_cols(d, 1'b0));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    frame_alternation_i = 1'b0;
    forced_blank_n_i = 1'b1;
    shift_direction_select_i = 1'b0;
    en_in = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    wt(4);
    check(column_outputs_o, exp_cols(80'h0, 1'b0));
    check({sample_overrun_o, sample_ready_o}, 2'h1);
    t_line(1'b0, 80'h0123456789ABCDEF0F1E);
    t_line(1'b1, 80'h80C3A5F00E17D22B4969);
    t_line(1'b0, 80'hFEDCBA9876543210A5C3);
    t_off(80'hFEDCBA9876543210A5C3);
    t_blank(80'hFEDCBA9876543210A5C3);
    close_out();
  end
endmodule
bind lcsc_loader lcsc_loader_props #(.COLS(COLS)) i_lcsc_loader_props (.clk_sys_i, .rst_i,
  .line_latch_pulse_i, .frame_alternation_i, .forced_blank_n_i, .shift_direction_select_i,
  .chain_enable_a_o, .chain_enable_a_oe_n_o, .chain_enable_b_o, .chain_enable_b_oe_n_o,
  .column_outputs_o, .sample_overrun_o);
